/* rtl/store_ref_pkg.sv */
// store_ref_pkg: instruction fields, function codes, timing constants and states
// assumes a single 25 MHz system clock
package store_ref_pkg;
    localparam int WORD_W = 18;
    localparam int N_W = 13;
    localparam int IO_SEL_W = 11;
    localparam int MOD_BIT = 17;
    localparam int F_HI = 16;
    localparam int F_LO = 13;
    localparam int UNIT_LO = 13;
    localparam int CLK_NS = 40;
    localparam int CNT_W = 10;
    localparam logic [3:0] F_ADD = 4'h1;
    localparam logic [3:0] F_SUB = 4'h2;
    localparam logic [3:0] F_AND = 4'h6;
    localparam logic [3:0] F_JZ = 4'h7;
    localparam logic [3:0] F_JMP = 4'h8;
    localparam logic [3:0] F_JN = 4'h9;
    localparam logic [3:0] F_CNT = 4'hA;
    localparam logic [3:0] F_MUL = 4'hC;
    localparam logic [3:0] F_FN14 = 4'hE;
    localparam logic [3:0] F_IO = 4'hF;
    localparam logic [12:0] IN_LO = 13'h0000;
    localparam logic [12:0] IN_HI = 13'h07FF;
    localparam logic [12:0] OUT_LO = 13'h1000;
    localparam logic [12:0] OUT_HI = 13'h17FF;
    localparam logic [17:0] PC_RESET = 18'h00000;
    localparam logic [17:0] WORD_RESET = 18'h00000;
    localparam logic SEL_RESET = 1'b0;
    // execution times in ns, faster store then slower store
    localparam int T_ADD_F = 3600;
    localparam int T_ADD_S = 6000;
    localparam int T_SUB_F = 4400;
    localparam int T_SUB_S = 6800;
    localparam int T_MUL_F = 10800;
    localparam int T_MUL_S = 13200;
    localparam int T_JS_F = 1200;
    localparam int T_JS_S = 2000;
    localparam int T_JT_F = 2400;
    localparam int T_JT_S = 4000;
    localparam int T_CNT_F = 4800;
    localparam int T_CNT_S = 8000;
    localparam int T_IO_F = 6400;
    localparam int T_IO_S = 8000;
    localparam int T_OTHER = 1200;
    localparam int C_ADD_F = (T_ADD_F + CLK_NS - 1) / CLK_NS;
    localparam int C_ADD_S = (T_ADD_S + CLK_NS - 1) / CLK_NS;
    localparam int C_SUB_F = (T_SUB_F + CLK_NS - 1) / CLK_NS;
    localparam int C_SUB_S = (T_SUB_S + CLK_NS - 1) / CLK_NS;
    localparam int C_MUL_F = (T_MUL_F + CLK_NS - 1) / CLK_NS;
    localparam int C_MUL_S = (T_MUL_S + CLK_NS - 1) / CLK_NS;
    localparam int C_JS_F = (T_JS_F + CLK_NS - 1) / CLK_NS;
    localparam int C_JS_S = (T_JS_S + CLK_NS - 1) / CLK_NS;
    localparam int C_JT_F = (T_JT_F + CLK_NS - 1) / CLK_NS;
    localparam int C_JT_S = (T_JT_S + CLK_NS - 1) / CLK_NS;
    localparam int C_CNT_F = (T_CNT_F + CLK_NS - 1) / CLK_NS;
    localparam int C_CNT_S = (T_CNT_S + CLK_NS - 1) / CLK_NS;
    localparam int C_IO_F = (T_IO_F + CLK_NS - 1) / CLK_NS;
    localparam int C_IO_S = (T_IO_S + CLK_NS - 1) / CLK_NS;
    localparam int C_OTHER = (T_OTHER + CLK_NS - 1) / CLK_NS;
    typedef enum logic [2:0] {
        ST_IDLE, ST_READ, ST_WRITE, ST_IO, ST_WAIT, ST_DONE
    } state_type;
endpackage : store_ref_pkg

/* rtl/store_ref_exec.sv */
// store_ref_exec: executes store-reference, jump, count and word input-output orders
// assumes a store that acknowledges each request with a one-cycle mem_ack and a
// peripheral that answers each select with a one-cycle io_reply
// Notes on behaviour
// [RULE1] function 1 adds the operand to the accumulator, the auxiliary register is altered.
// [RULE2] function 2 sets the accumulator to operand minus accumulator and copies the operand.
// [RULE3] function 12 places the double-length product of accumulator and operand in both.
// [RULE4] function 6 ands the operand into the accumulator, the auxiliary register is altered.
// [RULE5] function 7 jumps to the address only on a zero accumulator, taken costs double.
// [RULE6] function 8 always jumps to the address and alters the auxiliary register.
// [RULE7] function 9 jumps only on a negative accumulator, otherwise it takes the short time.
// [RULE8] function 10 adds one to the addressed store word and writes it back.
// [RULE9] function 15 with address 0 to 2047 inputs a word to the accumulator.
// [RULE10] function 15 with address 4096 to 6143 outputs the accumulator word.
// [RULE11] unit select zero puts the address field in the unit of the current instruction.
// [RULE12] unit select one makes non-jump addresses absolute within the first 8192 words.
// [RULE13] jumps always address within the current unit whatever the unit select holds.
// [RULE14] modified orders add the full 18-bit index register to the unmodified address.
// [RULE15] functions 14 and 15 ignore unit select and use the low 13 bits of the address; function 14 forms no address here and only waits T_OTHER.
// [RULE16] the console jump control clears the unit select register.
// [RULE17] bit 18 is the modifier flag, bits 17-14 the function, bits 13-1 the address.
`timescale 1ns/1ps
`default_nettype none
module store_ref_exec
    import store_ref_pkg::*;
#(
    parameter int W = WORD_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic slow_store,
    input wire logic instr_valid,
    input wire logic [W-1:0] instr,
    input wire logic [W-1:0] index_value,
    input wire logic console_jump,
    input wire logic select_load,
    input wire logic select_value,
    input wire logic mem_ack,
    input wire logic [W-1:0] mem_rdata,
    input wire logic io_reply,
    input wire logic [W-1:0] io_rdata,
    output logic busy,
    output logic done,
    output logic [W-1:0] acc,
    output logic [W-1:0] aux,
    output logic [W-1:0] pc,
    output logic unit_select,
    output logic mem_req,
    output logic mem_we,
    output logic [W-1:0] mem_addr,
    output logic [W-1:0] mem_wdata,
    output logic io_in_sel,
    output logic io_out_sel,
    output logic [IO_SEL_W-1:0] io_addr,
    output logic [W-1:0] io_wdata
);
    state_type state_reg;
    logic [3:0] func_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] need_reg;
    logic [W-1:0] acc_reg, aux_reg, pc_reg;
    logic sel_reg;
    logic busy_reg, done_reg;
    logic mem_req_reg, mem_we_reg;
    logic [W-1:0] mem_addr_reg, mem_wdata_reg;
    logic in_sel_reg, out_sel_reg;
    logic [IO_SEL_W-1:0] io_addr_reg;
    logic [W-1:0] io_wdata_reg;

    // instruction fields
    logic mod_flag;
    logic [3:0] func;
    logic [N_W-1:0] nfield;
    assign mod_flag = instr[MOD_BIT]; // RULE17
    assign func = instr[F_HI:F_LO]; // RULE17
    assign nfield = instr[N_W-1:0]; // RULE17

    function automatic logic is_jump(input logic [3:0] f);
        is_jump = (f == F_JZ) || (f == F_JMP) || (f == F_JN);
    endfunction : is_jump

    function automatic logic is_taken(input logic [3:0] f, input logic [W-1:0] a);
        is_taken = (f == F_JMP) || ((f == F_JZ) && (a == '0)) || ((f == F_JN) && a[W-1]);
    endfunction : is_taken

    function automatic logic [CNT_W-1:0] exec_cycles(input logic [3:0] f, input logic s,
                                                     input logic taken);
        int c;
        c = C_OTHER;
        case (f)
            F_ADD, F_AND: c = s ? C_ADD_S : C_ADD_F; // RULE1 RULE4
            F_SUB: c = s ? C_SUB_S : C_SUB_F; // RULE2
            F_MUL: c = s ? C_MUL_S : C_MUL_F; // RULE3
            F_JZ, F_JN: c = taken ? (s ? C_JT_S : C_JT_F) : (s ? C_JS_S : C_JS_F); // RULE5 RULE7
            F_JMP: c = s ? C_JT_S : C_JT_F; // RULE6
            F_CNT: c = s ? C_CNT_S : C_CNT_F; // RULE8
            F_IO: c = s ? C_IO_S : C_IO_F; // RULE9 RULE10
            default: c = C_OTHER;
        endcase
        exec_cycles = c[CNT_W-1:0];
    endfunction : exec_cycles

    // address formation
    logic [W-1:0] unit_addr, unmod_addr, mod_addr, index_term;
    logic [N_W-1:0] low13;
    assign unit_addr = {pc_reg[W-1:UNIT_LO], nfield}; // RULE11
    assign unmod_addr = (sel_reg && !is_jump(func)) ? {{(W-N_W){1'b0}}, nfield} // RULE12
                                                    : unit_addr; // RULE11 RULE13
    assign index_term = mod_flag ? index_value : '0;
    assign mod_addr = unmod_addr + index_term; // RULE14
    assign low13 = nfield + index_term[N_W-1:0]; // RULE15

    logic [2*W-1:0] product;
    assign product = $signed(acc_reg) * $signed(mem_rdata); // RULE3

    logic time_up;
    assign time_up = (cnt_reg >= need_reg);

    // sequencing and timing
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            func_reg <= 4'h0;
            cnt_reg <= '0;
            need_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (state_reg != ST_IDLE) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (instr_valid) begin
                        func_reg <= func;
                        cnt_reg <= 10'h001;
                        need_reg <= exec_cycles(func, slow_store, is_taken(func, acc_reg));
                        busy_reg <= 1'b1;
                        case (func)
                            F_ADD, F_SUB, F_AND, F_MUL, F_CNT: state_reg <= ST_READ;
                            F_IO: begin
                                if ((low13 <= IN_HI) ||
                                    ((low13 >= OUT_LO) && (low13 <= OUT_HI))) begin
                                    state_reg <= ST_IO; // RULE9 RULE10
                                end else begin
                                    state_reg <= ST_WAIT;
                                end
                            end
                            default: state_reg <= ST_WAIT;
                        endcase
                    end
                end
                ST_READ: begin
                    if (mem_ack) begin
                        state_reg <= (func_reg == F_CNT) ? ST_WRITE : ST_WAIT;
                    end
                end
                ST_WRITE: begin
                    if (mem_ack) begin
                        state_reg <= ST_WAIT;
                    end
                end
                ST_IO: begin
                    if (io_reply) begin
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (time_up) begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // store port
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mem_req_reg <= 1'b0;
            mem_we_reg <= 1'b0;
            mem_addr_reg <= WORD_RESET;
            mem_wdata_reg <= WORD_RESET;
        end else if (state_reg == ST_IDLE && instr_valid &&
                     (func == F_ADD || func == F_SUB || func == F_AND ||
                      func == F_MUL || func == F_CNT)) begin
            mem_req_reg <= 1'b1;
            mem_we_reg <= 1'b0;
            mem_addr_reg <= mod_addr;
        end else if (state_reg == ST_READ && mem_ack && func_reg == F_CNT) begin
            mem_we_reg <= 1'b1;
            mem_wdata_reg <= mem_rdata + 1'b1; // RULE8
        end else if (mem_ack) begin
            mem_req_reg <= 1'b0;
            mem_we_reg <= 1'b0;
        end
    end

    // peripheral port
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            in_sel_reg <= 1'b0;
            out_sel_reg <= 1'b0;
            io_addr_reg <= '0;
            io_wdata_reg <= WORD_RESET;
        end else if (state_reg == ST_IDLE && instr_valid && func == F_IO) begin
            io_addr_reg <= low13[IO_SEL_W-1:0]; // RULE9 RULE10
            in_sel_reg <= (low13 <= IN_HI); // RULE9
            out_sel_reg <= (low13 >= OUT_LO) && (low13 <= OUT_HI); // RULE10
            io_wdata_reg <= acc_reg; // RULE10
        end else if (io_reply) begin
            in_sel_reg <= 1'b0;
            out_sel_reg <= 1'b0;
        end
    end

    // accumulator and auxiliary register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            acc_reg <= WORD_RESET;
            aux_reg <= WORD_RESET;
        end else if (state_reg == ST_READ && mem_ack) begin
            case (func_reg)
                F_ADD: begin
                    acc_reg <= acc_reg + mem_rdata; // RULE1
                    aux_reg <= mem_rdata; // RULE1
                end
                F_SUB: begin
                    acc_reg <= mem_rdata - acc_reg; // RULE2
                    aux_reg <= mem_rdata; // RULE2
                end
                F_AND: begin
                    acc_reg <= acc_reg & mem_rdata; // RULE4
                    aux_reg <= mem_rdata; // RULE4
                end
                F_MUL: begin
                    acc_reg <= product[2*W-1:W]; // RULE3
                    aux_reg <= product[W-1:0]; // RULE3
                end
                F_CNT: aux_reg <= mem_rdata; // RULE8
                default: aux_reg <= aux_reg;
            endcase
        end else if (state_reg == ST_IO && io_reply) begin
            if (in_sel_reg) begin
                acc_reg <= io_rdata; // RULE9
            end
            aux_reg <= acc_reg; // RULE10
        end else if (state_reg == ST_IDLE && instr_valid && is_jump(func)) begin
            aux_reg <= pc_reg; // RULE5 RULE6 RULE7
        end
    end

    // program counter
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pc_reg <= PC_RESET;
        end else if (state_reg == ST_IDLE && instr_valid) begin
            if (is_taken(func, acc_reg)) begin
                pc_reg <= mod_addr; // RULE5 RULE6 RULE7 RULE13
            end else begin
                pc_reg <= pc_reg + 1'b1;
            end
        end
    end

    // store unit select register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sel_reg <= SEL_RESET;
        end else if (console_jump) begin
            sel_reg <= 1'b0; // RULE16
        end else if (select_load && !busy_reg) begin
            sel_reg <= select_value;
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;
    assign acc = acc_reg;
    assign aux = aux_reg;
    assign pc = pc_reg;
    assign unit_select = sel_reg;
    assign mem_req = mem_req_reg;
    assign mem_we = mem_we_reg;
    assign mem_addr = mem_addr_reg;
    assign mem_wdata = mem_wdata_reg;
    assign io_in_sel = in_sel_reg;
    assign io_out_sel = out_sel_reg;
    assign io_addr = io_addr_reg;
    assign io_wdata = io_wdata_reg;
endmodule : store_ref_exec
`default_nettype wire

/* verification/far_side.sv */
// far_side: core store and peripheral model facing store_ref_exec
// answers each request after lat idle cycles with a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module far_side (
    input wire logic sys_clk,
    input wire logic [3:0] lat,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [17:0] mem_addr,
    input wire logic [17:0] mem_wdata,
    input wire logic io_in_sel,
    input wire logic io_out_sel,
    input wire logic [10:0] io_addr,
    input wire logic [17:0] io_wdata,
    output logic mem_ack = 1'b0,
    output logic [17:0] mem_rdata = 18'h00000,
    output logic io_reply = 1'b0,
    output logic [17:0] io_rdata = 18'h00000,
    output logic [17:0] out_word = 18'h00000,
    output logic [10:0] out_addr = 11'h000
);
    logic [17:0] m [logic [17:0]];
    int wt = 0;
    // data lines toggle outside the answer cycle so stale data never looks valid
    always @(negedge sys_clk) begin
        mem_ack <= 1'b0;
        io_reply <= 1'b0;
        mem_rdata <= ~mem_rdata;
        io_rdata <= ~io_rdata;
        if ((mem_req || io_in_sel || io_out_sel) && !mem_ack && !io_reply) begin
            if (wt < int'(lat)) begin
                wt <= wt + 1;
            end else if (mem_req) begin
                wt <= 0;
                mem_ack <= 1'b1;
                if (mem_we) begin
                    m[mem_addr] = mem_wdata;
                end else begin
                    mem_rdata <= m.exists(mem_addr) ? m[mem_addr] : ~mem_addr;
                end
            end else begin
                wt <= 0;
                io_reply <= 1'b1;
                io_rdata <= {7'h2A, io_addr};
                if (io_out_sel) begin
                    out_word <= io_wdata;
                    out_addr <= io_addr;
                end
            end
        end
    end
endmodule : far_side
`default_nettype wire

/* verification/store_ref_exec_asserts.sv */
// store_ref_exec_asserts: port-level checks bound into store_ref_exec
// assumes the single sys_clk domain with synchronous rst
`timescale 1ns/1ps
`default_nettype none
module store_ref_exec_asserts
    import store_ref_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [17:0] instr,
    input wire logic [17:0] index_value,
    input wire logic console_jump,
    input wire logic mem_ack,
    input wire logic [17:0] mem_rdata,
    input wire logic busy,
    input wire logic done,
    input wire logic [17:0] acc,
    input wire logic [17:0] aux,
    input wire logic [17:0] pc,
    input wire logic unit_select,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [17:0] mem_addr,
    input wire logic [17:0] mem_wdata,
    input wire logic io_in_sel,
    input wire logic io_out_sel,
    input wire logic [10:0] io_addr
);
    logic [3:0] f_r;
    logic [17:0] ea_r;
    logic [17:0] a_r;
    logic [17:0] p_r;
    logic [17:0] x_r;
    logic [12:0] lo_r;
    logic signed [35:0] prod;
    wire logic jump = instr[16:13] inside {F_JZ, F_JMP, F_JN};
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // reference copy of the accepted order
    always_ff @(posedge sys_clk) begin
        if (instr_valid && !busy) begin
            f_r <= instr[16:13];
            a_r <= acc;
            p_r <= pc;
            ea_r <= ((unit_select && !jump) ? {5'h00, instr[12:0]} : {pc[17:13], instr[12:0]})
                + (instr[17] ? index_value : 18'h00000);
            lo_r <= instr[12:0] + index_value[12:0];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (mem_ack && !mem_we) begin
            x_r <= mem_rdata;
        end
    end
    always_comb prod = $signed(a_r) * $signed(x_r);
    a_mem_address: assert property (mem_req |-> mem_addr == ea_r)
        else $error("bad store address");
    a_jump_target: assert property ($rose(busy) && f_r == F_JMP |-> pc == ea_r)
        else $error("bad jump target");
    a_zero_jump: assert property ($rose(busy) && f_r == F_JZ |->
        pc == (~|a_r ? ea_r : p_r + 18'h00001)) else $error("bad zero jump");
    a_neg_jump: assert property ($rose(busy) && f_r == F_JN |->
        pc == (a_r[17] ? ea_r : p_r + 18'h00001)) else $error("bad negative jump");
    a_io_select: assert property ($rose(busy) && f_r == F_IO |->
        io_in_sel == (lo_r <= IN_HI) && io_out_sel == (lo_r >= OUT_LO && lo_r <= OUT_HI))
        else $error("bad peripheral select");
    a_io_addr: assert property (io_in_sel || io_out_sel |-> io_addr == lo_r[10:0])
        else $error("bad peripheral address");
    a_count_write: assert property (mem_req && mem_we |-> mem_wdata == x_r + 18'h00001)
        else $error("bad count value");
    a_add_result: assert property (done && f_r == F_ADD |-> acc == a_r + x_r)
        else $error("bad sum");
    a_sub_result: assert property (done && f_r == F_SUB |-> acc == x_r - a_r && aux == x_r)
        else $error("bad difference");
    a_mul_result: assert property (done && f_r == F_MUL |-> {acc, aux} == prod)
        else $error("bad product");
    a_console_clear: assert property (console_jump |=> !unit_select)
        else $error("unit select not cleared");
endmodule : store_ref_exec_asserts
bind store_ref_exec store_ref_exec_asserts i_store_ref_exec_asserts (
    .sys_clk, .rst, .instr_valid, .instr, .index_value, .console_jump, .mem_ack, .mem_rdata,
    .busy, .done, .acc, .aux, .pc, .unit_select, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .io_in_sel, .io_out_sel, .io_addr
);
`default_nettype wire

/* verification/store_ref_exec_test.sv */
// store_ref_exec_test: self-checking bench for store_ref_exec with the far_side model
// assumes a 25 MHz sys_clk and inputs driven on the falling edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module store_ref_exec_test
    import store_ref_pkg::*;
;
    localparam logic [17:0] z = 18'h00000;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic slow_store = 1'b0;
    logic instr_valid = 1'b0;
    logic console_jump = 1'b0;
    logic select_load = 1'b0;
    logic select_value = 1'b0;
    logic [17:0] instr = 18'h00000;
    logic [17:0] index_value = 18'h00000;
    logic [3:0] lat = 4'h0;
    logic mem_ack, io_reply, busy, done, unit_select, mem_req, mem_we, io_in_sel, io_out_sel;
    logic [17:0] mem_rdata, io_rdata, acc, aux, pc, mem_addr, mem_wdata, io_wdata, out_word;
    logic [10:0] io_addr;
    logic [10:0] out_addr;
    int bad_count = 0;
    int checks_done = 0;
    int n;
    store_ref_exec i_store_ref_exec (
        .sys_clk, .rst, .slow_store, .instr_valid, .instr, .index_value, .console_jump,
        .select_load, .select_value, .mem_ack, .mem_rdata, .io_reply, .io_rdata, .busy, .done,
        .acc, .aux, .pc, .unit_select, .mem_req, .mem_we, .mem_addr, .mem_wdata, .io_in_sel,
        .io_out_sel, .io_addr, .io_wdata
    );
    far_side i_far_side (
        .sys_clk, .lat, .mem_req, .mem_we, .mem_addr, .mem_wdata, .io_in_sel, .io_out_sel,
        .io_addr, .io_wdata, .mem_ack, .mem_rdata, .io_reply, .io_rdata, .out_word, .out_addr
    );
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    // one order: modifier set when an index is given, time judged against t cycles
    task automatic run(input logic [3:0] f, input logic [12:0] a, input logic [17:0] idx,
                       input logic s, input int t);
        @(negedge sys_clk);
        instr = {|idx, f, a};
        index_value = idx;
        slow_store = s;
        instr_valid = 1'b1;
        @(negedge sys_clk);
        instr_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
        `CHK("cycles", t + 1, n)
        @(negedge sys_clk);
    endtask : run
    task automatic sel(input logic v, input logic cj);
        @(negedge sys_clk);
        select_load = 1'b1;
        select_value = v;
        console_jump = cj;
        @(negedge sys_clk);
        select_load = 1'b0;
        console_jump = 1'b0;
    endtask : sel
    task automatic t_arith;
        i_far_side.m[18'h00010] = 18'h00005;
        i_far_side.m[18'h00011] = 18'h0000C;
        i_far_side.m[18'h00012] = 18'h3FFFD;
        i_far_side.m[18'h00013] = 18'h0F0F0;
        run(F_ADD, 13'h0010, z, 1'b0, C_ADD_F);
        `CHK("acc", 18'h00005, acc)
        run(F_SUB, 13'h0011, z, 1'b1, C_SUB_S);
        `CHK("aux", 18'h0000C, aux)
        run(F_MUL, 13'h0012, z, 1'b0, C_MUL_F);
        `CHK("product", 36'hFFFFFFFEB, {acc, aux})
        run(F_AND, 13'h0013, z, 1'b1, C_ADD_S);
        `CHK("acc", 18'h0F0F0, acc)
        $display("arith test finished");
    endtask : t_arith
    task automatic t_jump;
        i_far_side.m[18'h00014] = 18'h00000;
        i_far_side.m[18'h00015] = 18'h20000;
        run(F_JZ, 13'h0100, z, 1'b0, C_JS_F);
        `CHK("pc", 18'h00005, pc)
        run(F_AND, 13'h0014, z, 1'b0, C_ADD_F);
        run(F_JZ, 13'h0100, z, 1'b0, C_JT_F);
        `CHK("pc", 18'h00100, pc)
        run(F_JN, 13'h0200, z, 1'b1, C_JS_S);
        run(F_ADD, 13'h0015, z, 1'b0, C_ADD_F);
        run(F_JN, 13'h0200, z, 1'b1, C_JT_S);
        `CHK("pc", 18'h00200, pc)
        run(F_JMP, 13'h0005, 18'h02000, 1'b0, C_JT_F);
        `CHK("pc", 18'h02005, pc)
        sel(1'b1, 1'b0);
        run(F_JMP, 13'h0007, z, 1'b1, C_JT_S);
        `CHK("pc", 18'h02007, pc)
        $display("jump test finished");
    endtask : t_jump
    task automatic t_addr;
        i_far_side.m[18'h00020] = 18'h00001;
        i_far_side.m[18'h02020] = 18'h00002;
        i_far_side.m[18'h12003] = 18'h00010;
        i_far_side.m[18'h02030] = 18'h1FFFF;
        run(F_ADD, 13'h0020, z, 1'b0, C_ADD_F);
        `CHK("acc", 18'h20001, acc)
        sel(1'b0, 1'b0);
        run(F_ADD, 13'h0020, z, 1'b0, C_ADD_F);
        `CHK("acc", 18'h20003, acc)
        run(F_ADD, 13'h0003, 18'h10000, 1'b0, C_ADD_F);
        `CHK("acc", 18'h20013, acc)
        lat = 4'h3;
        run(F_CNT, 13'h0030, z, 1'b1, C_CNT_S);
        `CHK("count", 18'h20000, i_far_side.m[18'h02030])
        $display("address test finished");
    endtask : t_addr
    task automatic t_io;
        sel(1'b1, 1'b0);
        run(F_IO, 13'h07FF, z, 1'b0, C_IO_F);
        `CHK("input", 18'h157FF, acc)
        run(F_IO, 13'h1000, 18'h007FF, 1'b1, C_IO_S);
        `CHK("output", 18'h157FF, out_word)
        `CHK("outaddr", 11'h7FF, out_addr)
        run(F_IO, 13'h0800, z, 1'b0, C_IO_F);
        `CHK("acc", 18'h157FF, acc)
        sel(1'b1, 1'b1);
        `CHK("select", 1'b0, unit_select)
        $display("io test finished");
    endtask : t_io
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        t_arith();
        t_jump();
        t_addr();
        t_io();
        finish_test();
    end
    // orders need about 2300 cycles; allow over eight times that
    initial begin
        #800000;
        bad_count++;
        finish_test();
    end
endmodule : store_ref_exec_test
`default_nettype wire
